// ===== core/line_loopback_control.sv
// line loopback controller for one t1/e1 line channel: analog, remote,
// digital and dual loopback, automatic entry from in-band loop codes,
// data steering and diagnostic priority, and an apb register slave.
// assumes all data and detector inputs come from logic on clk_sys_in,
// one bit per line clock enable handled upstream.
`timescale 1ns/1ps
`default_nettype none

module line_loopback_control
  import loopback_pkg::*;
#(
  parameter int unsigned HOLD_CYCLES = HOLD_CYCLES_DEF
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  // apb slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // receive side data
  input wire logic line_rx_data_in,
  input wire diag_req_t rx_diag_in,
  // transmit side data
  input wire logic sys_tx_data_in,
  input wire logic tja_tx_data_in,
  input wire diag_req_t tx_diag_in,
  // in-band loop code detector
  input wire inband_loop_code_t inband_loop_code_in,
  // steered data outputs
  output logic shaper_data_out,
  output logic decoder_data_out,
  output logic sys_rx_data_out,
  output detect_taps_t detect_taps_out,
  // loopback state toward the analog front end and clocking
  output logic analog_loop_enable_out,
  output logic transmit_clock_ignore_out,
  output logic pattern_detect_in_transmit_out,
  output logic auto_loop_active_status_out
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0] loop_ctrl;
    logic pattern_detect_in_transmit;
    auto_state_t auto_state;
    logic auto_is_digital;
    logic [HOLD_CNT_W-1:0] hold_cnt;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic shaper;
    logic decoder;
    logic sys_rx;
    detect_taps_t taps;
    logic analog;
    logic tclk_ignore;
    logic auto_status;
  } state_t;

  state_t s_q;
  state_t s_d;

  localparam logic [HOLD_CNT_W-1:0] HOLD_LAST = HOLD_CNT_W'(HOLD_CYCLES - 1);

  // ----------------------------------------------------------------
  // decoded loopback modes
  // ----------------------------------------------------------------
  logic analog_on;
  logic auto_on;
  logic auto_remote;
  logic auto_digital;
  logic digital_on;
  logic remote_on;
  logic dual_on;
  logic dual_auto;
  logic code_activate;
  logic code_deactivate;
  logic hold_done;

  // the control bits steer the modes straight away; only the
  // automatic entry and exit are delayed by the code hold timer
  always_comb begin
    analog_on = s_q.loop_ctrl[ANALOG_BIT];
    auto_on = (s_q.auto_state == AUTO_ACTIVE) || (s_q.auto_state == AUTO_DISARM);
    auto_remote = auto_on && !s_q.auto_is_digital;
    auto_digital = auto_on && s_q.auto_is_digital;
    // analog overrides the other two loops
    digital_on = !analog_on && (s_q.loop_ctrl[DIGITAL_BIT] || auto_digital);
    // automatic remote is shut out while the digital loop is closed,
    // since the detector sits inside that loop
    remote_on = !analog_on
      && (s_q.loop_ctrl[REMOTE_BIT] || (auto_remote && !digital_on));
    // dual needs manual remote; auto remote never pairs with digital
    dual_on = remote_on && digital_on && s_q.loop_ctrl[REMOTE_BIT];
    dual_auto = dual_on && !s_q.loop_ctrl[DIGITAL_BIT];
    code_activate = inband_loop_code_in.activate;
    code_deactivate = inband_loop_code_in.deactivate;
    hold_done = (s_q.hold_cnt == HOLD_LAST);
  end

  // ----------------------------------------------------------------
  // data steering and diagnostic priority
  // ----------------------------------------------------------------
  logic tx_line;
  logic rx_decoder_in;
  logic rx_to_sys;

  // transmit path toward the waveform shaper
  always_comb begin
    tx_line = tja_tx_data_in;
    if (dual_on && dual_auto) begin
      // ais and transmit pattern both off, remote data goes out
      tx_line = line_rx_data_in;
    end else if (dual_on) begin
      // remote looped data wins over the pattern, ais off
      tx_line = line_rx_data_in;
    end else if (remote_on) begin
      // pattern over looped data; transmit ais suppressed
      if (tx_diag_in.pattern_en) begin
        tx_line = tx_diag_in.pattern_data;
      end else begin
        tx_line = line_rx_data_in;
      end
    end else if (digital_on) begin
      // pattern, then transmit data; transmit ais suppressed
      if (tx_diag_in.pattern_en) begin
        tx_line = tx_diag_in.pattern_data;
      end else begin
        tx_line = tja_tx_data_in;
      end
    end else if (analog_on) begin
      // ais generation suppressed, transmit still drives the line
      if (tx_diag_in.pattern_en) begin
        tx_line = tx_diag_in.pattern_data;
      end else begin
        tx_line = tja_tx_data_in;
      end
    end else begin
      // no loop: pattern, then ais, then transmit jitter attenuator data
      if (tx_diag_in.pattern_en) begin
        tx_line = tx_diag_in.pattern_data;
      end else if (tx_diag_in.ais_req) begin
        tx_line = 1'b1;
      end else begin
        tx_line = tja_tx_data_in;
      end
    end
  end

  // receive path: what enters the decoder, and what goes to the system
  always_comb begin
    rx_decoder_in = line_rx_data_in;
    if (analog_on) begin
      // receiver hears our own transmit signal, line data dropped
      rx_decoder_in = tx_line;
    end else if (digital_on) begin
      // transmit jitter attenuator output replaces the line
      rx_decoder_in = tja_tx_data_in;
    end
    rx_to_sys = rx_decoder_in;
    if (rx_diag_in.pattern_en) begin
      // pattern outranks looped data and ais in every mode
      rx_to_sys = rx_diag_in.pattern_data;
    end else if (rx_diag_in.ais_req && !analog_on && !digital_on) begin
      // receive ais is off in analog, digital and dual loops
      rx_to_sys = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // apb access decode
  // ----------------------------------------------------------------
  logic setup_phase;
  logic write_now;
  logic [31:0] read_word;
  logic addr_ok;

  // reads return the block's live loop state alongside the control bits
  always_comb begin
    setup_phase = psel_in && !penable_in;
    write_now = psel_in && penable_in && s_q.pready && pwrite_in;
    read_word = 32'h00000000;
    addr_ok = 1'b1;
    if (paddr_in == LOOP_CTRL_ADDR) begin
      read_word[3:0] = s_q.loop_ctrl;
    end else if (paddr_in == PD_CFG_ADDR) begin
      read_word[PATTERN_DETECT_IN_TRANSMIT_BIT] = s_q.pattern_detect_in_transmit;
    end else if (paddr_in == STATUS_ADDR) begin
      read_word[ST_ANALOG_BIT] = analog_on;
      read_word[ST_REMOTE_BIT] = remote_on;
      read_word[ST_DIGITAL_BIT] = digital_on;
      read_word[ST_DUAL_BIT] = dual_on;
      read_word[ST_AUTO_BIT] = s_q.auto_status;
    end else begin
      addr_ok = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;

    // apb: no wait states, answer staged in the setup cycle
    s_d.pready = setup_phase;
    if (setup_phase) begin
      s_d.prdata = pwrite_in ? 32'h00000000 : read_word;
      s_d.pslverr = !addr_ok;
    end else if (!psel_in || s_q.pready) begin
      s_d.prdata = 32'h00000000;
      s_d.pslverr = 1'b0;
    end
    if (write_now && paddr_in == LOOP_CTRL_ADDR) begin
      s_d.loop_ctrl = pwdata_in[3:0];
    end else if (write_now && paddr_in == PD_CFG_ADDR) begin
      // position changes during an automatic loop are the
      // software's to avoid; hardware keeps the latched kind
      s_d.pattern_detect_in_transmit = pwdata_in[PATTERN_DETECT_IN_TRANSMIT_BIT];
    end

    // automatic loop: hold timer over activate / deactivate codes
    case (s_q.auto_state)
      AUTO_IDLE: begin
        s_d.hold_cnt = HOLD_CNT_RESET;
        if (s_q.loop_ctrl[AUTO_BIT] && code_activate) begin
          s_d.auto_state = AUTO_ARM;
        end
      end
      AUTO_ARM: begin
        // code must hold unbroken for the whole hold time
        if (!s_q.loop_ctrl[AUTO_BIT] || !code_activate) begin
          s_d.auto_state = AUTO_IDLE;
          s_d.hold_cnt = HOLD_CNT_RESET;
        end else if (hold_done) begin
          s_d.auto_state = AUTO_ACTIVE;
          s_d.auto_is_digital = s_q.pattern_detect_in_transmit;
          s_d.hold_cnt = HOLD_CNT_RESET;
        end else begin
          s_d.hold_cnt = s_q.hold_cnt + HOLD_CNT_W'(1);
        end
      end
      AUTO_ACTIVE: begin
        s_d.hold_cnt = HOLD_CNT_RESET;
        if (!s_q.loop_ctrl[AUTO_BIT]) begin
          s_d.auto_state = AUTO_IDLE;
        end else if (code_deactivate) begin
          s_d.auto_state = AUTO_DISARM;
        end
      end
      AUTO_DISARM: begin
        if (!s_q.loop_ctrl[AUTO_BIT]) begin
          s_d.auto_state = AUTO_IDLE;
          s_d.hold_cnt = HOLD_CNT_RESET;
        end else if (!code_deactivate) begin
          s_d.auto_state = AUTO_ACTIVE;
          s_d.hold_cnt = HOLD_CNT_RESET;
        end else if (hold_done) begin
          s_d.auto_state = AUTO_IDLE;
          s_d.hold_cnt = HOLD_CNT_RESET;
        end else begin
          s_d.hold_cnt = s_q.hold_cnt + HOLD_CNT_W'(1);
        end
      end
      default: begin
        s_d.auto_state = AUTO_IDLE;
        s_d.hold_cnt = HOLD_CNT_RESET;
      end
    endcase
    // an automatic remote loop cannot stand while digital loop holds;
    // the next state is tested so that an entry refused on the very
    // edge it would happen never shows up on the status bit
    if ((s_d.auto_state == AUTO_ACTIVE || s_d.auto_state == AUTO_DISARM)
      && !s_d.auto_is_digital && digital_on) begin
      s_d.auto_state = AUTO_IDLE;
      s_d.hold_cnt = HOLD_CNT_RESET;
    end

    // registered outputs, one clock behind the selects
    s_d.shaper = tx_line;
    s_d.decoder = rx_decoder_in;
    // in a dual loop rx_to_sys already carries the digitally looped data
    s_d.sys_rx = rx_to_sys;
    // line loss / ais detectors watch the receiver input pins, or the looped transmit data in analog loop
    s_d.taps.rx_line_watch = analog_on ? tx_line : line_rx_data_in;
    // violation, zero and pattern detectors see decoder input
    s_d.taps.rx_code_watch = rx_decoder_in;
    // transmit detectors always see the system input
    s_d.taps.tx_sys_watch = sys_tx_data_in;
    s_d.analog = analog_on;
    s_d.tclk_ignore = remote_on;
    s_d.auto_status = (s_d.auto_state == AUTO_ACTIVE)
      || (s_d.auto_state == AUTO_DISARM);
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  // every field takes a constant under reset
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_q.loop_ctrl <= LOOP_CTRL_RESET;
      s_q.pattern_detect_in_transmit <= PATTERN_DETECT_IN_TRANSMIT_RESET;
      s_q.auto_state <= AUTO_IDLE;
      s_q.auto_is_digital <= 1'b0;
      s_q.hold_cnt <= HOLD_CNT_RESET;
      s_q.prdata <= 32'h00000000;
      s_q.pready <= 1'b0;
      s_q.pslverr <= 1'b0;
      s_q.shaper <= 1'b0;
      s_q.decoder <= 1'b0;
      s_q.sys_rx <= 1'b0;
      s_q.taps <= '0;
      s_q.analog <= 1'b0;
      s_q.tclk_ignore <= 1'b0;
      s_q.auto_status <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all straight from the state register
  // ----------------------------------------------------------------
  // one instance serves one channel; replicate per line channel
  assign prdata_out = s_q.prdata;
  assign pready_out = s_q.pready;
  assign pslverr_out = s_q.pslverr;
  assign shaper_data_out = s_q.shaper;
  assign decoder_data_out = s_q.decoder;
  assign sys_rx_data_out = s_q.sys_rx;
  assign detect_taps_out = s_q.taps;
  assign analog_loop_enable_out = s_q.analog;
  assign transmit_clock_ignore_out = s_q.tclk_ignore;
  assign pattern_detect_in_transmit_out = s_q.pattern_detect_in_transmit;
  assign auto_loop_active_status_out = s_q.auto_status;

endmodule

`default_nettype wire

// ===== core/loopback_pkg.sv
// package for the per-channel line loopback controller: register map,
// field positions, reset values, hold timing and the carrier types.
// assumes one channel per controller instance and a 40 MHz system clock.
package loopback_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses on the apb bus)
  // ----------------------------------------------------------------
  localparam logic [7:0] LOOP_CTRL_ADDR = 8'h00;
  localparam logic [7:0] PD_CFG_ADDR = 8'h04;
  localparam logic [7:0] STATUS_ADDR = 8'h08;

  // loop control register fields
  localparam int unsigned ANALOG_BIT = 0;
  localparam int unsigned REMOTE_BIT = 1;
  localparam int unsigned DIGITAL_BIT = 2;
  localparam int unsigned AUTO_BIT = 3;
  // pattern detect configuration register field
  localparam int unsigned PATTERN_DETECT_IN_TRANSMIT_BIT = 3;
  // status register fields
  localparam int unsigned ST_ANALOG_BIT = 0;
  localparam int unsigned ST_REMOTE_BIT = 1;
  localparam int unsigned ST_DIGITAL_BIT = 2;
  localparam int unsigned ST_DUAL_BIT = 3;
  localparam int unsigned ST_AUTO_BIT = 7;

  // reset values
  localparam logic [3:0] LOOP_CTRL_RESET = 4'h0;
  localparam logic PATTERN_DETECT_IN_TRANSMIT_RESET = 1'b0;
  localparam logic [27:0] HOLD_CNT_RESET = 28'h0000000;

  // ----------------------------------------------------------------
  // timing: in-band code must persist longer than the hold time
  // ----------------------------------------------------------------
  localparam int unsigned HOLD_TIME_MS = 5100;
  localparam int unsigned CLK_FREQ_KHZ = 40000;
  localparam int unsigned HOLD_CYCLES_DEF = HOLD_TIME_MS * CLK_FREQ_KHZ;
  localparam int unsigned HOLD_CNT_W = 28;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    AUTO_IDLE = 2'b00,
    AUTO_ARM = 2'b01,
    AUTO_ACTIVE = 2'b10,
    AUTO_DISARM = 2'b11
  } auto_state_t;

  // diagnostic requests from the pattern generator and ais generator
  typedef struct packed {
    logic pattern_en;
    logic pattern_data;
    logic ais_req;
  } diag_req_t;

  // in-band loop code indications from the pattern detector
  typedef struct packed {
    logic activate;
    logic deactivate;
  } inband_loop_code_t;

  // routed data taps toward detectors
  typedef struct packed {
    logic rx_line_watch;
    logic rx_code_watch;
    logic tx_sys_watch;
  } detect_taps_t;

endpackage

// ===== tb/loop_ctrl_check_sva.sv
// port checker for the line loopback controller
// assumes it is bound onto the controller, one clock domain
`timescale 1ns/1ps
`default_nettype none
module loop_ctrl_check
  import loopback_pkg::*;
#(
  parameter int unsigned HOLD_CYCLES = 20
) (
  // clock, reset and apb
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  // data and loop state
  input wire logic line_rx_data_in,
  input wire logic sys_tx_data_in,
  input wire diag_req_t tx_diag_in,
  input wire inband_loop_code_t inband_loop_code_in,
  input wire logic shaper_data_out,
  input wire detect_taps_t detect_taps_out,
  input wire logic analog_loop_enable_out,
  input wire logic transmit_clock_ignore_out,
  input wire logic auto_loop_active_status_out
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  logic [1:0] up_q;
  logic [31:0] act_q;
  // up_q hides the first edges, where $past still sees reset values
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      up_q <= 2'h0;
      act_q <= 32'h0;
    end else begin
      if (up_q != 2'h3) begin
        up_q <= up_q + 2'h1;
      end
      act_q <= inband_loop_code_in.activate ? act_q + 32'h1 : 32'h0;
    end
  end
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  property p_analog_alone;
    analog_loop_enable_out && $past(analog_loop_enable_out) |-> !transmit_clock_ignore_out;
  endproperty
  a_analog_alone: assert property (p_analog_alone) else $error("remote loop during analog");
  property p_remote_path;
    up_q == 2'h3 && transmit_clock_ignore_out && $past(transmit_clock_ignore_out)
      && !$past(tx_diag_in.pattern_en) |-> shaper_data_out == $past(line_rx_data_in);
  endproperty
  a_remote_path: assert property (p_remote_path) else $error("shaper not fed from line");
  property p_tx_watch;
    up_q == 2'h3 |-> detect_taps_out.tx_sys_watch == $past(sys_tx_data_in);
  endproperty
  a_tx_watch: assert property (p_tx_watch) else $error("tx detectors off system data");
  property p_rx_watch;
    up_q == 2'h3 && !analog_loop_enable_out |-> detect_taps_out.rx_line_watch == $past(line_rx_data_in);
  endproperty
  a_rx_watch: assert property (p_rx_watch) else $error("rx line detectors off line");
  property p_auto_off;
    auto_loop_active_status_out && psel_in && penable_in && pready_out && pwrite_in
      && paddr_in == LOOP_CTRL_ADDR && !pwdata_in[AUTO_BIT] |-> ##[1:2] !auto_loop_active_status_out;
  endproperty
  a_auto_off: assert property (p_auto_off) else $error("auto loop kept after clear");
  property p_auto_hold;
    $rose(auto_loop_active_status_out) |-> act_q >= HOLD_CYCLES;
  endproperty
  a_auto_hold: assert property (p_auto_hold) else $error("auto loop entered early");
  property p_status_read;
    psel_in && !penable_in && !pwrite_in && paddr_in == STATUS_ADDR
      |=> prdata_out[ST_AUTO_BIT] == $past(auto_loop_active_status_out);
  endproperty
  a_status_read: assert property (p_status_read) else $error("status auto bit wrong");
  property p_apb_answer;
    psel_in && !penable_in |=> pready_out ##1 !pready_out;
  endproperty
  a_apb_answer: assert property (p_apb_answer) else $error("apb ready timing");
  property p_unmapped;
    psel_in && !penable_in && paddr_in > STATUS_ADDR |=> pslverr_out && prdata_out == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
  c_auto: cover property ($rose(auto_loop_active_status_out));
  c_analog: cover property (analog_loop_enable_out);
  c_remote: cover property (transmit_clock_ignore_out);
  c_err: cover property (pslverr_out);
endmodule
bind line_loopback_control loop_ctrl_check #(.HOLD_CYCLES(HOLD_CYCLES)) u_loop_ctrl_check (.*);
`default_nettype wire

// ===== tb/loop_far_model.sv
// far-side model: line receive data, framer transmit data, in-band codes
// assumes the bench sets levels and code kind; all change on a clock edge
`timescale 1ns/1ps
`default_nettype none
module loop_far_model
  import loopback_pkg::*;
(
  // clock and commands
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic line_lvl_in,
  input wire logic sys_lvl_in,
  input wire logic [1:0] code_in,
  // toward the controller
  output logic line_rx_data_out,
  output logic sys_tx_data_out,
  output inband_loop_code_t code_out
);
  // the detector reports one code at a time, never both
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      line_rx_data_out <= 1'b0;
      sys_tx_data_out <= 1'b0;
      code_out <= 2'h0;
    end else begin
      line_rx_data_out <= line_lvl_in;
      sys_tx_data_out <= sys_lvl_in;
      code_out.activate <= code_in == 2'h1;
      code_out.deactivate <= code_in == 2'h2;
    end
  end
endmodule
`default_nettype wire

// ===== tb/line_loopback_control_tb.sv
// self-checking bench for the line loopback controller
// assumes the far-side model and the bound port checker
`timescale 1ns/1ps
`default_nettype none
module line_loopback_control_tb
  import loopback_pkg::*;
;
  logic clk_sys_in, rst_n_in, psel_in, penable_in, pwrite_in, pready_out, pslverr_out;
  logic [7:0] paddr_in;
  logic [31:0] pwdata_in, prdata_out;
  logic line_rx_data_in, sys_tx_data_in, tja_tx_data_in, shaper_data_out, decoder_data_out;
  logic sys_rx_data_out, analog_loop_enable_out, transmit_clock_ignore_out;
  logic pattern_detect_in_transmit_out, auto_loop_active_status_out;
  logic line_lvl, sys_lvl;
  logic [1:0] code;
  diag_req_t rx_diag_in, tx_diag_in;
  inband_loop_code_t inband_loop_code_in;
  detect_taps_t detect_taps_out;
  int err_total, tests_run, hi_cnt;
  logic [6:0] ov;
  assign ov = {shaper_data_out, decoder_data_out, sys_rx_data_out, detect_taps_out.rx_line_watch,
               detect_taps_out.tx_sys_watch, analog_loop_enable_out, transmit_clock_ignore_out};
  // short hold count keeps the automatic loop scenarios brief
  line_loopback_control #(.HOLD_CYCLES(20)) u_line_loopback_control (.*);
  loop_far_model u_loop_far_model (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
    .line_lvl_in(line_lvl), .sys_lvl_in(sys_lvl), .code_in(code),
    .line_rx_data_out(line_rx_data_in), .sys_tx_data_out(sys_tx_data_in),
    .code_out(inband_loop_code_in));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic close_out();
    $display("tests_run=%0d err_total=%0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // apb master: request held until ready is seen at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    @(posedge clk_sys_in);
    psel_in <= 1'b1;
    pwrite_in <= wr;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_sys_in);
    penable_in <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys_in);
      n++;
    end while (pready_out !== 1'b1 && n < 16);
    if (pready_out !== 1'b1) begin
      chk(32'h1, 32'h0, "apb timeout");
      close_out();
    end
    q = prdata_out;
    e = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    chk(q, x, "read data");
    chk({31'h0, e}, {31'h0, xe}, "slverr");
  endtask
  // set all stream inputs, then let them settle through the registers
  task automatic drv(input logic l, input logic s, input logic t, input logic [2:0] r,
                     input logic [2:0] x);
    @(posedge clk_sys_in);
    line_lvl <= l;
    sys_lvl <= s;
    tja_tx_data_in <= t;
    rx_diag_in <= r;
    tx_diag_in <= x;
    repeat (4) @(posedge clk_sys_in);
  endtask
  task automatic wait_auto(input logic v, input int lim);
    int n;
    n = 0;
    while (auto_loop_active_status_out !== v && n < lim) begin
      @(posedge clk_sys_in);
      n++;
    end
    chk({31'h0, auto_loop_active_status_out}, {31'h0, v}, "auto status");
    if (auto_loop_active_status_out !== v) begin
      close_out();
    end
  endtask
  task automatic set_code(input logic [1:0] c);
    @(posedge clk_sys_in);
    code <= c;
  endtask
  initial begin
    clk_sys_in = 1'b0;
    forever #12.5 clk_sys_in = ~clk_sys_in;
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    err_total = 0;
    tests_run = 0;
    rst_n_in = 1'b0;
    psel_in = 1'b0;
    penable_in = 1'b0;
    pwrite_in = 1'b0;
    paddr_in = 8'h00;
    pwdata_in = 32'h0;
    line_lvl = 1'b0;
    sys_lvl = 1'b0;
    code = 2'h0;
    tja_tx_data_in = 1'b0;
    rx_diag_in = 3'h0;
    tx_diag_in = 3'h0;
    repeat (5) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    rd(LOOP_CTRL_ADDR, 32'h0, 1'b0);
    rd(PD_CFG_ADDR, 32'h0, 1'b0);
    wr(STATUS_ADDR, 32'hff);
    rd(STATUS_ADDR, 32'h0, 1'b0);
    wr(8'h10, 32'h7);
    rd(8'h0c, 32'h0, 1'b1);
    rd(LOOP_CTRL_ADDR, 32'h0, 1'b0);
    $display("test registers done");
    wr(LOOP_CTRL_ADDR, 32'h7);
    drv(1'b0, 1'b1, 1'b0, 3'h6, 3'h1);
    chk({25'h0, ov}, 32'h16, "analog paths");
    rd(STATUS_ADDR, 32'h1, 1'b0);
    drv(1'b1, 1'b1, 1'b0, 3'h0, 3'h0);
    chk({31'h0, decoder_data_out}, 32'h0, "analog loop data");
    $display("test analog done");
    wr(LOOP_CTRL_ADDR, 32'h2);
    drv(1'b1, 1'b0, 1'b0, 3'h5, 3'h1);
    chk({25'h0, ov}, 32'h69, "remote paths");
    drv(1'b1, 1'b0, 1'b0, 3'h0, 3'h4);
    chk({25'h0, ov}, 32'h39, "remote pattern");
    rd(STATUS_ADDR, 32'h2, 1'b0);
    $display("test remote done");
    wr(LOOP_CTRL_ADDR, 32'h4);
    drv(1'b1, 1'b1, 1'b0, 3'h1, 3'h1);
    chk({25'h0, ov}, 32'h0c, "digital paths");
    drv(1'b0, 1'b0, 1'b1, 3'h6, 3'h4);
    chk({25'h0, ov}, 32'h30, "digital pattern");
    rd(STATUS_ADDR, 32'h4, 1'b0);
    $display("test digital done");
    wr(LOOP_CTRL_ADDR, 32'h6);
    drv(1'b1, 1'b0, 1'b0, 3'h1, 3'h5);
    chk({25'h0, ov}, 32'h49, "dual paths");
    chk({31'h0, detect_taps_out.rx_code_watch}, 32'h0, "dual code tap");
    drv(1'b0, 1'b1, 1'b1, 3'h6, 3'h0);
    chk({25'h0, ov}, 32'h35, "dual pattern");
    rd(STATUS_ADDR, 32'he, 1'b0);
    wr(LOOP_CTRL_ADDR, 32'h0);
    drv(1'b0, 1'b0, 1'b0, 3'h0, 3'h0);
    $display("test dual done");
    wr(LOOP_CTRL_ADDR, 32'h8);
    set_code(2'h1);
    repeat (10) @(posedge clk_sys_in);
    chk({31'h0, auto_loop_active_status_out}, 32'h0, "auto early");
    wait_auto(1'b1, 60);
    rd(STATUS_ADDR, 32'h82, 1'b0);
    set_code(2'h2);
    wait_auto(1'b0, 60);
    set_code(2'h1);
    wait_auto(1'b1, 60);
    set_code(2'h0);
    wr(LOOP_CTRL_ADDR, 32'h0);
    wait_auto(1'b0, 3);
    $display("test auto remote done");
    wr(LOOP_CTRL_ADDR, 32'hc);
    set_code(2'h1);
    hi_cnt = 0;
    repeat (60) begin
      @(posedge clk_sys_in);
      if (auto_loop_active_status_out !== 1'b0 || transmit_clock_ignore_out !== 1'b0) begin
        hi_cnt++;
      end
    end
    chk(hi_cnt, 32'h0, "auto under digital");
    set_code(2'h0);
    wr(LOOP_CTRL_ADDR, 32'h0);
    $display("test auto blocked done");
    wr(PD_CFG_ADDR, 32'h8);
    @(posedge clk_sys_in);
    chk({31'h0, pattern_detect_in_transmit_out}, 32'h1, "pd position");
    wr(LOOP_CTRL_ADDR, 32'ha);
    set_code(2'h1);
    wait_auto(1'b1, 60);
    set_code(2'h0);
    rd(STATUS_ADDR, 32'h8e, 1'b0);
    drv(1'b1, 1'b0, 1'b0, 3'h6, 3'h4);
    chk({25'h0, ov}, 32'h59, "dual auto paths");
    wr(LOOP_CTRL_ADDR, 32'h0);
    wait_auto(1'b0, 3);
    wr(PD_CFG_ADDR, 32'h0);
    $display("test auto digital done");
    close_out();
  end
endmodule
`default_nettype wire
